// File: hdl/tpwg_pkg.sv
/*
 * Package for the timer PWM waveform generator: register offsets, field
 * layouts, reset values and mode codes.
 * Assumes a single 10 MHz clock domain and a classic Wishbone register bus.
 */
package tpwg_pkg;
    // Byte offsets of the register words
    localparam logic [3:0] TPWG_OFS_CTRL = 4'h0;
    localparam logic [3:0] TPWG_OFS_CMPA = 4'h4;
    localparam logic [3:0] TPWG_OFS_CMPB = 4'h8;
    localparam logic [3:0] TPWG_OFS_STAT = 4'hC;
    // Control word field positions
    localparam int TPWG_CTRL_MODE_LSB = 0;
    localparam int TPWG_CTRL_COMA_LSB = 4;
    localparam int TPWG_CTRL_COMB_LSB = 6;
    localparam int TPWG_CTRL_DIRA_BIT = 8;
    localparam int TPWG_CTRL_DIRB_BIT = 9;
    // Status word field positions
    localparam int TPWG_STAT_OVF_BIT = 0;
    localparam int TPWG_STAT_MFA_BIT = 1;
    localparam int TPWG_STAT_MFB_BIT = 2;
    localparam int TPWG_STAT_CNT_LSB = 8;
    localparam int TPWG_STAT_WVA_BIT = 16;
    localparam int TPWG_STAT_WVB_BIT = 17;
    localparam int TPWG_STAT_UP_BIT = 18;
    // Mode codes of the waveform mode select field
    localparam logic [2:0] TPWG_MODE_FAST_FF = 3'h3;
    localparam logic [2:0] TPWG_MODE_FAST_CA = 3'h7;
    localparam logic [2:0] TPWG_MODE_PC_FF = 3'h1;
    localparam logic [2:0] TPWG_MODE_PC_CA = 3'h5;
    // Compare output mode codes
    localparam logic [1:0] TPWG_COM_OFF = 2'h0;
    localparam logic [1:0] TPWG_COM_TOGGLE = 2'h1;
    localparam logic [1:0] TPWG_COM_NONINV = 2'h2;
    localparam logic [1:0] TPWG_COM_INV = 2'h3;
    // Counter limits and reset values
    localparam logic [7:0] TPWG_BOTTOM = 8'h00;
    localparam logic [7:0] TPWG_MAX = 8'hFF;
    localparam logic [7:0] TPWG_CMP_RESET = 8'h00;
    localparam logic [2:0] TPWG_MODE_RESET = 3'h0;

    // Wishbone request bundle
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } tpwg_wb_req_t;

    // Counting state of the dual slope sequencer
    typedef enum logic [1:0] {
        TPWG_DIR_UP = 2'b01,
        TPWG_DIR_DOWN = 2'b10
    } tpwg_dir_t;
endpackage : tpwg_pkg

// File: hdl/tpwg_top.sv
/*
 * Timer PWM waveform generator: 8-bit counter with fast and phase correct
 * PWM, two compare channels, buffered compare values, overflow and match
 * flags, and pin output with direction control, behind a Wishbone slave.
 * Assumes timer_tick_in is a one-cycle enable from a prescaler on sys_clk_in.
 */
// Design decisions made here: the address map and the Wishbone interface to the registers.
// Overview of operation
// - Modes 3 and 7 select fast PWM
// - Fast top is 0xFF or compare A
// - Fast: count up to top, wrap zero
// - Fast: clear on match, set bottom; inverse
// - Fast: field two normal, three inverted
// - Fast bottom update on wrap tick
// - Fast: overflow flag set at top
// - Fast mode one toggles A if high bit
// - Fast extremes: spike at bottom, flat max
// - Compare values double buffered in PWM
// - Fast 0xFF period is 256 ticks
// - Modes 1 and 5 select phase correct
// - Phase top is 0xFF or compare A
// - Phase: up, hold top one tick, down
// - Phase: clear matching up, set down
// - Phase: overflow flag set at bottom
// - Phase 0xFF period is 510 ticks
// - Phase extremes: bottom low, max high
// - At max output follows up-match result unless compare is max
// - Missed up match still applied at top
// - Synchronous counter, tick is clock enable
// - Field zero: no action, pin released
// - Pin driven only when direction is output
module tpwg_top #(
    parameter int CNT_W = 8
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic timer_tick_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    output logic wave_out_a_out,
    output logic wave_out_a_oe_out,
    output logic wave_out_b_out,
    output logic wave_out_b_oe_out
);
    import tpwg_pkg::*;

    tpwg_wb_req_t req;
    logic [2:0] waveform_mode_select;
    logic [1:0] compare_output_mode_a;
    logic [1:0] compare_output_mode_b;
    logic dir_a;
    logic dir_b;
    logic [CNT_W-1:0] cmp_a_buf;
    logic [CNT_W-1:0] cmp_b_buf;
    logic [CNT_W-1:0] cmp_a_act;
    logic [CNT_W-1:0] cmp_b_act;
    logic [CNT_W-1:0] count_value;
    tpwg_dir_t dir;
    logic wave_a;
    logic wave_b;
    logic overflow_flag;
    logic match_flag_a;
    logic match_flag_b;
    logic wr_hit;
    logic rd_hit;
    logic fast_mode;
    logic pc_mode;
    logic mode_select_high_bit;
    logic [CNT_W-1:0] top_value;
    logic at_top;
    logic at_bottom;
    logic match_a;
    logic match_b;
    logic load_cmp;
    logic next_wave_a;
    logic next_wave_b;
    logic [CNT_W-1:0] next_count;
    tpwg_dir_t next_dir;
    logic [31:0] next_rdata;
    logic clr_ovf;
    logic clr_mfa;
    logic clr_mfb;
    logic [CNT_W-1:0] cmp_a_eff;
    logic [CNT_W-1:0] cmp_b_eff;
    logic [CNT_W-1:0] top_eff;
    logic up_eff;
    logic [31:0] ctl_merged;

    // Byte lane merge on a write: sel bit picks which byte of old is replaced
    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // Output action of one channel on this tick; toggle only when allowed
    function automatic logic wave_step(input logic cur, input logic [1:0] com, input logic fast,
                                       input logic match, input logic top, input logic wrap,
                                       input logic up, input logic tgl_ok, input logic cmp_is_top);
        logic res;
        res = cur;
        if (com == TPWG_COM_TOGGLE) begin
            if (tgl_ok && match) begin
                res = ~cur;
            end
        end else if (com[1]) begin
            if (fast) begin
                // Bottom action wins over a match ignored at top
                if (wrap) begin
                    res = (com == TPWG_COM_NONINV);
                end else if (match && !cmp_is_top) begin
                    res = (com == TPWG_COM_INV);
                end
            end else if (top) begin
                // At top the state is forced to the up-match result, or to its inverse for a compare at top, which keeps
                // symmetry and recovers a match skipped on the way up
                res = (com == TPWG_COM_INV) ^ cmp_is_top;
            end else if (match) begin
                res = up ? (com == TPWG_COM_INV) : (com == TPWG_COM_NONINV);
            end
        end
        // Field zero leaves the state untouched
        return res;
    endfunction : wave_step

    assign req = '{cyc: wb_cyc_in, stb: wb_stb_in, we: wb_we_in, adr: wb_adr_in,
                   sel: wb_sel_in, dat: wb_dat_in};

    // Mode decode
    assign fast_mode = (waveform_mode_select == TPWG_MODE_FAST_FF) ||
                       (waveform_mode_select == TPWG_MODE_FAST_CA);
    assign pc_mode = (waveform_mode_select == TPWG_MODE_PC_FF) ||
                     (waveform_mode_select == TPWG_MODE_PC_CA);
    assign mode_select_high_bit = waveform_mode_select[2];
    assign top_value = mode_select_high_bit ? cmp_a_act : CNT_W'(TPWG_MAX);
    assign at_top = (count_value == top_value);
    assign at_bottom = (count_value == CNT_W'(TPWG_BOTTOM));
    assign match_a = (count_value == cmp_a_act);
    assign match_b = (count_value == cmp_b_act);
    // Load point of the buffered compares
    assign load_cmp = timer_tick_in && (fast_mode || pc_mode) && at_top;
    // On a load tick the incoming compares decide the top action, so a compare
    // leaving max already gives the up-match result there
    assign cmp_a_eff = load_cmp ? cmp_a_buf : cmp_a_act;
    assign cmp_b_eff = load_cmp ? cmp_b_buf : cmp_b_act;
    assign top_eff = mode_select_high_bit ? cmp_a_eff : CNT_W'(TPWG_MAX);
    // A match at bottom counts as up-counting, so compare at bottom stays flat
    assign up_eff = (dir == TPWG_DIR_UP) || at_bottom;

    // Next counter value and direction; top held exactly one tick
    always_comb begin
        next_count = count_value;
        next_dir = dir;
        if (fast_mode) begin
            next_dir = TPWG_DIR_UP;
            next_count = at_top ? CNT_W'(TPWG_BOTTOM) : count_value + 1'b1;
        end else if (pc_mode) begin
            if (at_top) begin
                next_dir = TPWG_DIR_DOWN;
                next_count = count_value - 1'b1;
            end else if (at_bottom) begin
                next_dir = TPWG_DIR_UP;
                next_count = count_value + 1'b1;
            end else if (dir == TPWG_DIR_UP) begin
                next_count = count_value + 1'b1;
            end else begin
                next_count = count_value - 1'b1;
            end
        end
    end

    // Channel output state for this tick
    always_comb begin
        next_wave_a = wave_step(wave_a, compare_output_mode_a, fast_mode, match_a, at_top,
                                at_top, up_eff, mode_select_high_bit,
                                cmp_a_eff == top_eff);
        // Channel B never toggles
        next_wave_b = wave_step(wave_b, compare_output_mode_b, fast_mode, match_b, at_top,
                                at_top, up_eff, 1'b0, cmp_b_eff >= top_eff);
    end

    // Counter advances only on the tick enable
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            count_value <= CNT_W'(TPWG_BOTTOM);
            dir <= TPWG_DIR_UP;
        end else if (timer_tick_in) begin
            count_value <= next_count;
            dir <= next_dir;
        end
    end

    // Output compare state, reset to low
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            wave_a <= 1'b0;
            wave_b <= 1'b0;
        end else if (timer_tick_in && (fast_mode || pc_mode)) begin
            wave_a <= next_wave_a;
            wave_b <= next_wave_b;
        end
    end

    // Active compare values follow the buffers at top
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            cmp_a_act <= CNT_W'(TPWG_CMP_RESET);
            cmp_b_act <= CNT_W'(TPWG_CMP_RESET);
        end else if (load_cmp || !(fast_mode || pc_mode)) begin
            cmp_a_act <= cmp_a_buf;
            cmp_b_act <= cmp_b_buf;
        end
    end

    // Bus decode
    assign wr_hit = req.cyc && req.stb && req.we && !wb_ack_out;
    assign rd_hit = req.cyc && req.stb && !req.we && !wb_ack_out;
    assign clr_ovf = wr_hit && req.adr == TPWG_OFS_STAT && req.sel[0] && req.dat[TPWG_STAT_OVF_BIT];
    assign clr_mfa = wr_hit && req.adr == TPWG_OFS_STAT && req.sel[0] && req.dat[TPWG_STAT_MFA_BIT];
    assign clr_mfb = wr_hit && req.adr == TPWG_OFS_STAT && req.sel[0] && req.dat[TPWG_STAT_MFB_BIT];

    // Flags: hardware set wins over a write-one clear in the same cycle
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            overflow_flag <= 1'b0;
            match_flag_a <= 1'b0;
            match_flag_b <= 1'b0;
        end else begin
            if (timer_tick_in && ((fast_mode && at_top) || (pc_mode && at_bottom))) begin
                overflow_flag <= 1'b1;
            end else if (clr_ovf) begin
                overflow_flag <= 1'b0;
            end
            if (timer_tick_in && match_a) begin
                match_flag_a <= 1'b1;
            end else if (clr_mfa) begin
                match_flag_a <= 1'b0;
            end
            if (timer_tick_in && match_b) begin
                match_flag_b <= 1'b1;
            end else if (clr_mfb) begin
                match_flag_b <= 1'b0;
            end
        end
    end

    // Control word with the written byte lanes merged in
    assign ctl_merged = merge_bytes({22'h0, dir_b, dir_a, compare_output_mode_b,
                                     compare_output_mode_a, 1'b0, waveform_mode_select},
                                    req.dat, req.sel);

    // Control and buffered compare registers
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            waveform_mode_select <= TPWG_MODE_RESET;
            compare_output_mode_a <= TPWG_COM_OFF;
            compare_output_mode_b <= TPWG_COM_OFF;
            dir_a <= 1'b0;
            dir_b <= 1'b0;
            cmp_a_buf <= CNT_W'(TPWG_CMP_RESET);
            cmp_b_buf <= CNT_W'(TPWG_CMP_RESET);
        end else if (wr_hit) begin
            unique case (req.adr)
                TPWG_OFS_CTRL: begin
                    waveform_mode_select <= ctl_merged[TPWG_CTRL_MODE_LSB +: 3];
                    compare_output_mode_a <= ctl_merged[TPWG_CTRL_COMA_LSB +: 2];
                    compare_output_mode_b <= ctl_merged[TPWG_CTRL_COMB_LSB +: 2];
                    dir_a <= ctl_merged[TPWG_CTRL_DIRA_BIT];
                    dir_b <= ctl_merged[TPWG_CTRL_DIRB_BIT];
                end
                TPWG_OFS_CMPA: begin
                    if (req.sel[0]) begin
                        cmp_a_buf <= req.dat[CNT_W-1:0];
                    end
                end
                TPWG_OFS_CMPB: begin
                    if (req.sel[0]) begin
                        cmp_b_buf <= req.dat[CNT_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        next_rdata = '0;
        unique case (req.adr)
            TPWG_OFS_CTRL: begin
                next_rdata = {22'h0, dir_b, dir_a, compare_output_mode_b, compare_output_mode_a,
                              1'b0, waveform_mode_select};
            end
            TPWG_OFS_CMPA: begin
                next_rdata[CNT_W-1:0] = cmp_a_buf;
            end
            TPWG_OFS_CMPB: begin
                next_rdata[CNT_W-1:0] = cmp_b_buf;
            end
            TPWG_OFS_STAT: begin
                next_rdata[TPWG_STAT_OVF_BIT] = overflow_flag;
                next_rdata[TPWG_STAT_MFA_BIT] = match_flag_a;
                next_rdata[TPWG_STAT_MFB_BIT] = match_flag_b;
                next_rdata[TPWG_STAT_CNT_LSB +: CNT_W] = count_value;
                next_rdata[TPWG_STAT_WVA_BIT] = wave_a;
                next_rdata[TPWG_STAT_WVB_BIT] = wave_b;
                next_rdata[TPWG_STAT_UP_BIT] = (dir == TPWG_DIR_UP);
            end
            default: begin
            end
        endcase
    end

    // One-cycle ack, one cycle after the request is seen
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= '0;
        end else begin
            wb_ack_out <= wr_hit || rd_hit;
            wb_dat_out <= rd_hit ? next_rdata : '0;
        end
    end

    // Pins: driven only when the field is nonzero and direction is output
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            wave_out_a_out <= 1'b0;
            wave_out_a_oe_out <= 1'b0;
            wave_out_b_out <= 1'b0;
            wave_out_b_oe_out <= 1'b0;
        end else begin
            wave_out_a_out <= wave_a;
            wave_out_b_out <= wave_b;
            wave_out_a_oe_out <= dir_a && (compare_output_mode_a != TPWG_COM_OFF);
            wave_out_b_oe_out <= dir_b && (compare_output_mode_b != TPWG_COM_OFF);
        end
    end
endmodule : tpwg_top

// File: test/tpwg_checker.sv
/*
 * Port-level checker for the timer PWM waveform generator.
 * Assumes one clock domain and a synchronous active-high reset.
 */
module tpwg_checker #(
    parameter int CNT_W = 8
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic timer_tick_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic wave_out_a_out,
    input wire logic wave_out_a_oe_out,
    input wire logic wave_out_b_out,
    input wire logic wave_out_b_oe_out
);
    import tpwg_pkg::*;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    // Bus handshake: one answer per request, one cycle wide
    ack_follows_req_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("ack missing after request");
    ack_one_cycle_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held too long");
    ack_needs_req_a: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
        else $error("ack without request");
    data_idle_zero_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
        else $error("read data not zero while idle");
    unmapped_zero_a: assert property (wb_ack_out && !wb_we_in && wb_adr_in[1:0] != 2'h0 |-> wb_dat_out == 32'h0)
        else $error("unmapped read not zero");
    ctrl_spare_a: assert property (wb_ack_out && !wb_we_in && wb_adr_in == TPWG_OFS_CTRL
        |-> wb_dat_out[31:10] == 22'h0 && !wb_dat_out[3]) else $error("spare control bits set");
    // Pins move only after a tick or a register access, never on their own
    wave_on_tick_a: assert property ($changed(wave_out_a_out) || $changed(wave_out_b_out)
        |-> $past(timer_tick_in, 2) || $past(wb_stb_in, 2)) else $error("wave moved without tick");
    oe_from_write_a: assert property ($changed(wave_out_a_oe_out) || $changed(wave_out_b_oe_out)
        |-> $past(wb_we_in && wb_stb_in) || $past(wb_we_in && wb_stb_in, 2)) else $error("enable moved");
    // Reset must clear the ack and all four pin outputs, so it cannot be the disable here
    reset_clears_a: assert property (disable iff (1'b0) sys_rst_in |=> !wb_ack_out && !wave_out_a_out
        && !wave_out_b_out && !wave_out_a_oe_out && !wave_out_b_oe_out) else $error("outputs not cleared");
    cover property (wb_ack_out && wb_we_in);
    cover property ($rose(wave_out_a_out));
    cover property ($fell(wave_out_b_out));
endmodule : tpwg_checker

// File: test/tpwg_tb_top.sv
/*
 * Self-checking bench for the timer PWM waveform generator.
 * Assumes the tick is ours to drive; ticks stop while registers are read.
 */
module tpwg_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import tpwg_pkg::*;
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic tick = 1'b0;
    tpwg_wb_req_t req = '0;
    logic [31:0] rdat;
    logic ack, wa, wa_oe, wb, wb_oe;
    int err_total = 0;
    int cmp_count = 0;
    tpwg_top #(.CNT_W(8)) dut_u (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .timer_tick_in(tick),
        .wb_cyc_in(req.cyc), .wb_stb_in(req.stb), .wb_we_in(req.we), .wb_adr_in(req.adr), .wb_sel_in(req.sel),
        .wb_dat_in(req.dat), .wb_dat_out(rdat), .wb_ack_out(ack), .wave_out_a_out(wa),
        .wave_out_a_oe_out(wa_oe), .wave_out_b_out(wb), .wave_out_b_oe_out(wb_oe));
    // 100 ns period
    always #50 sys_clk_in = ~sys_clk_in;
    task automatic chk_w(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_w
    task automatic chk_b(string nm, logic e, logic g);
        chk_w(nm, {31'h0, e}, {31'h0, g});
    endtask : chk_b
    // Classic cycle; only the watchdog ends the wait, and the ack delay is judged
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk_in) req <= '{1'b1, 1'b1, w, a, 4'hF, d};
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (ack !== 1'b1);
        chk_w("ack delay", 32'h2, n);
        q = rdat;
        req <= '0;
    endtask : bus
    task automatic wr(logic [3:0] a, logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(string nm, logic [3:0] a, logic [31:0] m, logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk_w(nm, e & m, q & m);
    endtask : rd
    task automatic ctl(logic [2:0] md, logic [1:0] ca, logic [1:0] cb);
        wr(TPWG_OFS_CTRL, {22'h0, 2'b11, cb, ca, 1'b0, md});
    endtask : ctl
    // Status expectation: count, wave A, wave B, up, overflow
    task automatic st(logic [7:0] c, logic a, logic b, logic u, logic o, logic [31:0] m);
        rd("status", TPWG_OFS_STAT, m, {13'h0, u, b, a, c, 7'h0, o});
    endtask : st
    // Gapped ticks prove the tick is only an enable
    task automatic tk(int n, bit gap);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk_in) tick <= 1'b1;
            if (gap) begin
                @(posedge sys_clk_in) tick <= 1'b0;
            end
        end
        @(posedge sys_clk_in) tick <= 1'b0;
    endtask : tk
    task automatic do_rst();
        @(posedge sys_clk_in) sys_rst_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
    endtask : do_rst
    task automatic t_reset();
        rd("ctrl", TPWG_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
        st(8'h00, 0, 0, 1, 0, 32'hFFFFFFFF);
        wr(4'h1, 32'hFFFFFFFF);
        rd("unmapped", 4'h1, 32'hFFFFFFFF, 32'h0);
        rd("ctrl kept", TPWG_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
        chk_b("oe a", 1'b0, wa_oe);
    endtask : t_reset
    task automatic t_fast();
        do_rst();
        wr(TPWG_OFS_CMPA, 32'h40);
        wr(TPWG_OFS_CMPB, 32'h20);
        ctl(3'h3, 2'h2, 2'h2);
        // Enables are registered: look once they have settled
        @(negedge sys_clk_in);
        chk_b("oe a", 1'b1, wa_oe);
        chk_b("oe b", 1'b1, wb_oe);
        tk(8'h50, 1);
        st(8'h50, 0, 0, 0, 0, 32'h0003FF01);
        rd("match flags", TPWG_OFS_STAT, 32'h6, 32'h6);
        wr(TPWG_OFS_STAT, 32'h6);
        rd("flags cleared", TPWG_OFS_STAT, 32'h6, 32'h0);
        tk(8'hAF, 0);
        st(8'hFF, 0, 0, 0, 0, 32'h0003FF01);
        tk(1, 0);
        st(8'h00, 1, 1, 0, 1, 32'h0003FF01);
        chk_b("pin a", 1'b1, wa);
        chk_b("pin b", 1'b1, wb);
        tk(8'h41, 0);
        st(8'h41, 0, 0, 0, 1, 32'h0003FF01);
        wr(TPWG_OFS_STAT, 32'h1);
        tk(8'hBF, 0);
        st(8'h00, 1, 1, 0, 1, 32'h0003FF01);
        ctl(3'h3, 2'h3, 2'h2);
        tk(8'h41, 0);
        st(8'h41, 1, 0, 0, 1, 32'h0003FF01);
        tk(8'hBF, 0);
        st(8'h00, 0, 1, 0, 1, 32'h0003FF01);
    endtask : t_fast
    task automatic t_top_a();
        do_rst();
        wr(TPWG_OFS_CMPA, 32'h0F);
        ctl(3'h7, 2'h2, 2'h1);
        tk(8'h0F, 0);
        st(8'h0F, 0, 0, 0, 0, 32'h0003FF01);
        tk(1, 0);
        st(8'h00, 1, 0, 0, 1, 32'h0003FF01);
        tk(8, 0);
        st(8'h08, 1, 0, 0, 1, 32'h0003FF01);
        ctl(3'h3, 2'h1, 2'h0);
        tk(256, 0);
        st(8'h08, 1, 0, 0, 1, 32'h0003FF01);
        chk_b("oe b", 1'b0, wb_oe);
        // Compare A as top again: mode one now toggles A on its match
        ctl(3'h7, 2'h1, 2'h0);
        tk(8, 0);
        st(8'h00, 0, 0, 0, 1, 32'h0003FF01);
    endtask : t_top_a
    task automatic t_phase();
        do_rst();
        wr(TPWG_OFS_CMPA, 32'h10);
        wr(TPWG_OFS_CMPB, 32'h10);
        ctl(3'h1, 2'h2, 2'h3);
        tk(8'h11, 0);
        st(8'h11, 0, 1, 1, 1, 32'h0007FF01);
        wr(TPWG_OFS_STAT, 32'h1);
        tk(8'hEE, 0);
        st(8'hFF, 0, 1, 1, 0, 32'h0007FF01);
        tk(1, 0);
        st(8'hFE, 0, 1, 0, 0, 32'h0007FF01);
        tk(8'hEF, 0);
        st(8'h0F, 1, 0, 0, 0, 32'h0007FF01);
        tk(8'h0F, 0);
        st(8'h00, 1, 0, 0, 0, 32'h0003FF01);
        tk(1, 0);
        st(8'h01, 1, 0, 1, 1, 32'h0007FF01);
    endtask : t_phase
    task automatic t_phase_ext();
        do_rst();
        wr(TPWG_OFS_CMPA, 32'hFF);
        ctl(3'h1, 2'h2, 2'h0);
        tk(600, 0);
        st(8'h5A, 1, 0, 1, 1, 32'h0005FF01);
        wr(TPWG_OFS_CMPA, 32'h00);
        tk(1, 0);
        st(8'h5B, 1, 0, 1, 1, 32'h0005FF01);
        tk(8'hA5, 0);
        st(8'hFE, 0, 0, 0, 1, 32'h0005FF01);
        tk(512, 1);
        st(8'hFC, 0, 0, 0, 1, 32'h0007FF01);
    endtask : t_phase_ext
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    // Main sequence after a three-cycle reset
    initial begin
        repeat (3) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        t_reset();
        t_fast();
        t_top_a();
        t_phase();
        t_phase_ext();
        complete_run();
    end
    // About twice the expected run length
    initial begin
        #800000;
        err_total++;
        complete_run();
    end
endmodule : tpwg_tb_top

bind tpwg_top tpwg_checker #(.CNT_W(CNT_W)) chk_u (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .timer_tick_in(timer_tick_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .wave_out_a_out(wave_out_a_out), .wave_out_a_oe_out(wave_out_a_oe_out),
    .wave_out_b_out(wave_out_b_out), .wave_out_b_oe_out(wave_out_b_oe_out));
